//--- verification/efa_alarm_irq_tb.sv
// self-checking bench for the alarm status and interrupt block
`timescale 1ns/1ps
`default_nettype none
module efa_alarm_irq_tb;
    import efa_pkg::*;

    logic        mclk;
    logic        resetn;
    efa_bus_t    bus;
    logic [7:0]  rdata;
    efa_events_t evt;
    efa_status_t raw;
    logic        forceReframe;
    logic        irq;
    int          badCount;
    int          samplesChecked;
    int          cycles = 0;
    int          sel;
    logic [7:0]  regs [8] = '{8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h30};

    // short persistence and search counts keep the run brief
    efa_alarm_irq #(.PERSIST_CYCLES(20), .SEARCH_CYCLES(30)) efa_alarm_irq_inst (
        .mclk(mclk), .resetn(resetn), .bus(bus), .rdata(rdata), .evt(evt), .raw(raw),
        .forceReframe(forceReframe), .irq(irq));

    efa_cpu_model efa_cpu_model_inst (.mclk(mclk), .bus(bus), .rdata(rdata));

    always #4 mclk = ~mclk;

    // ****
    // helpers
    // ****
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samplesChecked++;
        if (seen !== exp)
        begin
            badCount++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic chkBit(input string what, input logic seen, input logic exp);
        check(what, {7'h00, seen}, {7'h00, exp});
    endtask : chkBit

    task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        efa_cpu_model_inst.regRead(a, d);
        check($sformatf("register %h", a), d, exp);
    endtask : rdChk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        efa_cpu_model_inst.regWrite(a, d);
    endtask : wr

    // land one step past the edge so registered outputs are settled
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : cyc

    task automatic pulse(input efa_events_t e);
        @(posedge mclk);
        evt <= e;
        @(posedge mclk);
        evt <= '0;
    endtask : pulse

    task automatic strobe(input efa_status_t s);
        @(posedge mclk);
        raw <= raw | s;
        @(posedge mclk);
        raw <= raw & ~s;
    endtask : strobe

    task automatic doReset();
        @(posedge mclk);
        resetn <= 1'b0;
        evt <= '0;
        raw <= '0;
        cyc(4);
        resetn <= 1'b1;
        cyc(1);
    endtask : doReset

    task automatic results();
        $display("checks %0d mismatches %0d", samplesChecked, badCount);
        if (badCount == 0 && samplesChecked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : results

    // a hang counts as a mismatch
    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            badCount++;
            results();
        end
    end

    initial
    begin
        mclk = 1'b0;
        resetn = 1'b0;
        evt = '0;
        raw = '0;
        badCount = 0;
        samplesChecked = 0;
        cyc(4);
        resetn <= 1'b1;
        cyc(1);
        // ****
        // reset values, read-only and unmapped places
        // ****
        foreach (regs[i])
            rdChk(regs[i], 8'h00);
        wr(8'h23, 8'hA5);
        wr(8'h27, 8'hFF);
        rdChk(8'h23, 8'hA5);
        rdChk(8'h27, 8'h00);
        $display("test access done");
        // ****
        // alarm events, enables and clear on read
        // ****
        wr(8'h23, 8'h02);
        pulse('{rxCrcErr: 1'b1, default: 1'b0});
        cyc(3);
        chkBit("irq", irq, 1'b0);
        pulse('{rxFebeZero: 1'b1, default: 1'b0});
        cyc(3);
        chkBit("irq", irq, 1'b1);
        rdChk(8'h25, 8'h03);
        cyc(2);
        chkBit("irq", irq, 1'b0);
        rdChk(8'h25, 8'h00);
        $display("test alarm events done");
        // ****
        // framing error events accumulate until read
        // ****
        pulse('{rxFrameErr: 1'b1, default: 1'b0});
        pulse('{rxFrameErr: 1'b1, rxSigMfErr: 1'b1, rxCrcMfErr: 1'b1,
                rxAlignChange: 1'b1, default: 1'b0});
        cyc(2);
        rdChk(8'h24, 8'h0F);
        rdChk(8'h24, 8'h00);
        $display("test framing errors done");
        // ****
        // frame loss both edges and persistent loss filter
        // ****
        doReset();
        wr(8'h22, 8'h40);
        @(posedge mclk);
        raw.frameLost <= 1'b1;
        cyc(3);
        rdChk(8'h26, 8'h50);
        chkBit("irq", irq, 1'b1);
        rdChk(8'h24, 8'h50);
        cyc(2);
        chkBit("irq", irq, 1'b0);
        rdChk(8'h27, 8'h00);
        cyc(25);
        rdChk(8'h27, 8'h08);
        @(posedge mclk);
        raw.frameLost <= 1'b0;
        cyc(3);
        rdChk(8'h26, 8'h00);
        rdChk(8'h24, 8'h50);
        rdChk(8'h27, 8'h08);
        cyc(30);
        rdChk(8'h27, 8'h00);
        rdChk(8'h25, 8'h08);
        $display("test frame loss done");
        // ****
        // multiframe search timer
        // ****
        @(posedge mclk);
        raw.crcMfSearch <= 1'b1;
        cyc(10);
        chkBit("reframe", forceReframe, 1'b0);
        cyc(30);
        chkBit("reframe", forceReframe, 1'b1);
        wr(8'h26, 8'h02);
        cyc(3);
        chkBit("reframe", forceReframe, 1'b0);
        rdChk(8'h26, 8'h02);
        $display("test search timer done");
        // ****
        // errored multiframe words, loss on and off
        // ****
        for (sel = 0; sel < 2; sel++)
        begin
            doReset();
            wr(8'h26, 8'(sel));
            repeat (3) pulse('{rxCrcMfErr: 1'b1, default: 1'b0});
            cyc(2);
            rdChk(8'h26, 8'(sel));
            pulse('{rxCrcMfErr: 1'b1, default: 1'b0});
            cyc(2);
            rdChk(8'h26, (sel == 1) ? 8'h01 : 8'h50);
        end
        $display("test multiframe words done");
        // ****
        // remote alarm debounce at both settings
        // ****
        for (sel = 0; sel < 2; sel++)
        begin
            doReset();
            wr(8'h21, (sel == 1) ? 8'h08 : 8'h00);
            wr(8'h23, 8'h80);
            repeat (1 + sel) strobe('{nfasStrobe: 1'b1, remoteAlarmBit: 1'b1, default: 1'b0});
            cyc(2);
            rdChk(8'h27, 8'h00);
            repeat (3) strobe('{nfasStrobe: 1'b1, remoteAlarmBit: 1'b1, default: 1'b0});
            cyc(2);
            rdChk(8'h27, 8'h80);
            chkBit("irq", irq, 1'b1);
        end
        $display("test remote alarm done");
        // ****
        // all-ones, timeslot 16 and remote multiframe statuses
        // ****
        doReset();
        strobe('{aisWindowStrobe: 1'b1, aisWindowOnes: 1'b1, default: 1'b0});
        @(posedge mclk);
        raw.sigMfLost <= 1'b1;
        repeat (2) strobe('{ts16Strobe: 1'b1, ts16AllOnes: 1'b1, default: 1'b0});
        cyc(2);
        rdChk(8'h27, 8'h30);
        rdChk(8'h27, 8'h30);
        repeat (2) strobe('{mfStrobe: 1'b1, remoteMfBit: 1'b1, default: 1'b0});
        cyc(2);
        rdChk(8'h27, 8'h70);
        rdChk(8'h25, 8'h70);
        $display("test other statuses done");
        results();
    end

endmodule : efa_alarm_irq_tb
`default_nettype wire

//--- verification/efa_cpu_model.sv
// register bus master standing in for the microprocessor
`timescale 1ns/1ps
`default_nettype none
module efa_cpu_model
    import efa_pkg::*;
(
    // clock
    input  wire logic              mclk,
    // register port
    output var  efa_pkg::efa_bus_t bus,
    input  wire logic [7:0]        rdata
);

    initial
    begin
        bus = '0;
    end

    // one-cycle strobes, released at the edge that samples them
    task automatic regWrite(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        bus.wr <= 1'b0;
    endtask : regWrite

    // read data stand only in the cycle after the strobe
    task automatic regRead(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        bus.rd <= 1'b0;
        #1;
        d = rdata;
    endtask : regRead

endmodule : efa_cpu_model
`default_nettype wire

//--- verilog/efa_alarm_irq.sv
// alarm status, clear-on-read indications and interrupt for one E1 receive channel
// Contract
// RQ1 - enabled alarm status changes raise interrupt
// RQ2 - zero far-end bit sets indication
// RQ3 - CRC mismatch sets indication
// RQ4 - framing states flag both edges
// RQ5 - framing errors flag since last read
// RQ6 - indications ignore enables; read clears
// RQ7 - framing read withdraws its interrupt
// RQ8 - alarm read withdraws its interrupt
// RQ9 - alarm indication on change or event
// RQ10 - frame-loss status while alignment lost
// RQ11 - multiframe losses while alignment lost (code forces only the CRC loss; the signalling loss is raw.sigMfLost alone)
// RQ12 - search timer reframe unless disabled
// RQ13 - four bad words drop CRC multiframe
// RQ14 - disabled: drop only on frame/CRC excess
// RQ15 - remote alarm debounced on A bit
// RQ16 - remote multiframe alarm on Y bit
// RQ17 - all-ones detect per 512-bit window
// RQ18 - timeslot 16 all-ones twice while lost
// RQ19 - red alarm after 100 ms loss
// RQ20 - red alarm clears after 100 ms absent
// RQ21 - all-ones alarm with 100 ms hysteresis
// RQ22 - framing enables gate state-change interrupts
// RQ23 - debounce select picks 2 or 3
// RQ24 - interrupt holds while enabled indication set
//
// Implementation choice: the plain strobed port.
`include "efa_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module efa_alarm_irq
    import efa_pkg::*;
#(
    parameter int unsigned PERSIST_CYCLES = `EFA_PERSIST_CYCLES,
    parameter int unsigned SEARCH_CYCLES  = `EFA_SEARCH_CYCLES
)
(
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             resetn,
    // register port
    input  wire efa_pkg::efa_bus_t bus,
    output var  logic [7:0]       rdata,
    // framer core events and raw states
    input  wire efa_pkg::efa_events_t evt,
    input  wire efa_pkg::efa_status_t raw,
    // outputs to framer core and system
    output var  logic             forceReframe,
    output var  logic             irq
);
    import efa_pkg::*;

    // ************************************************************
    // registers and decode
    // ************************************************************
    logic [7:0] alarmEn;
    logic [7:0] frameEn;
    logic [7:0] frameInd;
    logic [7:0] alarmInd;
    logic [1:0] frameCtl;
    logic [1:0] debounceSel;
    logic [7:0] alarmStat;
    logic       crcMfLoss;
    logic       crcMfLossPrev;
    logic       oofPrev;
    logic       sigPrev;
    logic [7:2] alarmPrev;

    wire wrAlarmEn  = bus.wr && (bus.addr == `EFA_ADDR_ALARM_EN);
    wire wrFrameEn  = bus.wr && (bus.addr == `EFA_ADDR_FRAME_EN);
    wire wrFrameCtl = bus.wr && (bus.addr == `EFA_ADDR_FRAME_STAT);
    wire wrDebounce = bus.wr && (bus.addr == `EFA_ADDR_DEBOUNCE);
    wire rdFrameInd = bus.rd && (bus.addr == `EFA_ADDR_FRAME_IND);
    wire rdAlarmInd = bus.rd && (bus.addr == `EFA_ADDR_ALARM_IND);

    // ************************************************************
    // framing state and CRC multiframe loss
    // ************************************************************
    logic [2:0]  mfasRun;
    logic [9:0]  crcCount;
    logic [20:0] searchCount;
    wire         timerOff    = frameCtl[`EFA_BIT_TIMER_OFF];
    wire         mfasOff     = frameCtl[`EFA_BIT_MFAS_OFF];
    wire         crcExcess   = (crcCount > `EFA_CRC_ERR_LIMIT);
    wire         mfasLimit   = (mfasRun >= `EFA_MFAS_ERR_LIMIT);
    wire         searchFull  = (searchCount >= SEARCH_CYCLES[20:0]);
    wire         loseByWords = !mfasOff && mfasLimit; // RQ13
    wire         next_crcMfLoss = raw.frameLost || crcExcess || loseByWords
                                  || (raw.crcMfLost && crcMfLoss); // RQ14
    wire         oofNow   = raw.frameLost || loseByWords; // RQ10 RQ13
    wire         sigNow   = raw.sigMfLost; // RQ11
    wire         crcNow   = crcMfLoss; // RQ11

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            mfasRun     <= 3'h0;
            crcCount    <= 10'h000;
            searchCount <= 21'h000000;
            crcMfLoss   <= 1'b0;
            forceReframe <= 1'b0;
        end
        else
        begin
            if (evt.rxCrcMfErr)
                mfasRun <= mfasLimit ? mfasRun : mfasRun + 3'h1;
            // only a good alignment word ends the loss, so the run holds at its limit
            else if (raw.mfStrobe)
                mfasRun <= 3'h0;
            if (evt.secondTick)
                crcCount <= 10'h000;
            else if (evt.rxCrcErr && !crcExcess)
                crcCount <= crcCount + 10'h001;
            searchCount <= (raw.crcMfSearch && !searchFull) ? searchCount + 21'h000001
                         : (raw.crcMfSearch ? searchCount : 21'h000000);
            crcMfLoss    <= next_crcMfLoss;
            forceReframe <= raw.crcMfSearch && searchFull && !timerOff; // RQ12
        end
    end

    // ************************************************************
    // maintenance statuses
    // ************************************************************
    logic [1:0] aRun;
    logic [1:0] yRun;
    logic       aLast;
    logic       yLast;
    logic       nfasPhase;
    logic       remoteAlarm;
    logic       remoteMfAlarm;
    logic       allOnesDetect;
    logic       ts16Prev;
    logic       ts16Detect;
    logic       redState;
    logic       aisState;
    wire [1:0]  aNeed = debounceSel[1] ? 2'h3 : 2'h2; // RQ23
    wire [1:0]  yNeed = debounceSel[0] ? 2'h3 : 2'h2;

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            aRun <= 2'h0; yRun <= 2'h0; aLast <= 1'b0; yLast <= 1'b0;
            nfasPhase <= 1'b0; remoteAlarm <= 1'b0; remoteMfAlarm <= 1'b0;
            allOnesDetect <= 1'b0; ts16Prev <= 1'b0; ts16Detect <= 1'b0;
        end
        else
        begin
            if (raw.nfasStrobe)
            begin
                aLast     <= raw.remoteAlarmBit;
                aRun      <= (raw.remoteAlarmBit != aLast) ? 2'h1
                           : ((aRun == 2'h3) ? aRun : aRun + 2'h1);
                nfasPhase <= ~nfasPhase;
                if (nfasPhase && aRun >= aNeed - 2'h1 && raw.remoteAlarmBit == aLast)
                    remoteAlarm <= aLast; // RQ15
            end
            if (raw.mfStrobe)
            begin
                yLast <= raw.remoteMfBit;
                yRun  <= (raw.remoteMfBit != yLast) ? 2'h1
                       : ((yRun == 2'h3) ? yRun : yRun + 2'h1);
                if (yRun >= yNeed - 2'h1 && raw.remoteMfBit == yLast)
                    remoteMfAlarm <= yLast; // RQ16
            end
            if (raw.aisWindowStrobe)
                allOnesDetect <= raw.aisWindowOnes; // RQ17
            if (raw.ts16Strobe)
            begin
                ts16Prev   <= raw.ts16AllOnes;
                ts16Detect <= raw.ts16AllOnes && ts16Prev && raw.sigMfLost; // RQ18
            end
        end
    end

    efa_persist #(.HOLD(PERSIST_CYCLES)) redFilter
    (
        .mclk      (mclk),
        .resetn    (resetn),
        .condition (oofNow),
        .state     (redState)
    ); // RQ19 RQ20

    efa_persist #(.HOLD(PERSIST_CYCLES)) aisFilter
    (
        .mclk      (mclk),
        .resetn    (resetn),
        .condition (oofNow && allOnesDetect),
        .state     (aisState)
    ); // RQ21

    wire [7:0] next_alarmStat = {remoteAlarm, remoteMfAlarm, allOnesDetect, ts16Detect,
                                 redState, aisState, 2'b00};

    // ************************************************************
    // indications, read clear with set priority
    // ************************************************************
    wire [7:0] frameSet = {1'b0, oofNow != oofPrev, sigNow != sigPrev,
                           crcNow != crcMfLossPrev, evt.rxAlignChange,
                           evt.rxFrameErr, evt.rxSigMfErr, evt.rxCrcMfErr}; // RQ4 RQ5
    wire [7:0] alarmSet = {next_alarmStat[7:2] ^ alarmPrev,
                           evt.rxFebeZero, evt.rxCrcErr}; // RQ2 RQ3 RQ9
    wire [7:0] next_frameInd = (rdFrameInd ? 8'h00 : frameInd) | frameSet; // RQ6 RQ7
    wire [7:0] next_alarmInd = (rdAlarmInd ? 8'h00 : alarmInd) | alarmSet; // RQ6 RQ8
    wire       next_irq = |(next_frameInd & frameEn) || |(next_alarmInd & alarmEn); // RQ1 RQ22 RQ24

    wire [7:0] next_rdata =
        (bus.addr == `EFA_ADDR_ALARM_EN)   ? alarmEn :
        (bus.addr == `EFA_ADDR_FRAME_EN)   ? frameEn :
        (bus.addr == `EFA_ADDR_FRAME_IND)  ? frameInd :
        (bus.addr == `EFA_ADDR_ALARM_IND)  ? alarmInd :
        (bus.addr == `EFA_ADDR_FRAME_STAT) ? {1'b0, oofPrev, sigPrev, crcMfLossPrev, 2'b00, frameCtl} :
        (bus.addr == `EFA_ADDR_ALARM_STAT) ? alarmStat :
        (bus.addr == `EFA_ADDR_DEBOUNCE)   ? {4'h0, debounceSel, 2'b00} : 8'h00;

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            alarmEn <= `EFA_RESET_BYTE; frameEn <= `EFA_RESET_BYTE;
            frameInd <= `EFA_RESET_BYTE; alarmInd <= `EFA_RESET_BYTE;
            frameCtl <= 2'b00; debounceSel <= 2'b00; alarmStat <= `EFA_RESET_BYTE;
            oofPrev <= 1'b0; sigPrev <= 1'b0; crcMfLossPrev <= 1'b0; alarmPrev <= 6'h00;
            rdata <= 8'h00; irq <= 1'b0;
        end
        else
        begin
            if (wrAlarmEn)  alarmEn <= bus.wdata;
            if (wrFrameEn)  frameEn <= {1'b0, bus.wdata[6:0]};
            if (wrFrameCtl) frameCtl <= bus.wdata[1:0];
            if (wrDebounce) debounceSel <= bus.wdata[`EFA_BIT_REMOTE_ALARM_DEBOUNCE_SEL:`EFA_BIT_REMOTE_MF_DEBOUNCE_SEL];
            frameInd <= next_frameInd;
            alarmInd <= next_alarmInd;
            alarmStat <= next_alarmStat;
            alarmPrev <= next_alarmStat[7:2];
            oofPrev <= oofNow; sigPrev <= sigNow; crcMfLossPrev <= crcNow;
            rdata <= bus.rd ? next_rdata : 8'h00;
            irq <= next_irq;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    a_crc_sets_ind: assert property (@(posedge mclk) disable iff (!resetn)
        evt.rxCrcErr |=> alarmInd[`EFA_BIT_CRCE]) else $error("crc event lost"); // RQ3
    a_febe_sets_ind: assert property (@(posedge mclk) disable iff (!resetn)
        evt.rxFebeZero |=> alarmInd[`EFA_BIT_FEBE]) else $error("febe event lost"); // RQ2
    a_oof_edge_ind: assert property (@(posedge mclk) disable iff (!resetn)
        $changed(oofPrev) |-> frameInd[`EFA_BIT_OOF]) else $error("oof edge missed"); // RQ4
    a_read_clears: assert property (@(posedge mclk) disable iff (!resetn)
        (rdAlarmInd && !evt.rxCrcErr && !evt.rxFebeZero && $stable(next_alarmStat[7:2])
         && next_alarmStat[7:2] == alarmPrev) |=> alarmInd == 8'h00) else $error("no clear"); // RQ6
    a_irq_follows: assert property (@(posedge mclk) disable iff (!resetn)
        irq == (|($past(next_frameInd & frameEn)) || |($past(next_alarmInd & alarmEn))))
        else $error("irq mismatch"); // RQ24
    a_timer_off: assert property (@(posedge mclk) disable iff (!resetn)
        $past(timerOff) |-> !forceReframe) else $error("reframe while disabled"); // RQ12
    a_words_lose: assert property (@(posedge mclk) disable iff (!resetn)
        (!mfasOff && mfasLimit) |=> crcMfLoss) else $error("mf loss missed"); // RQ13
    a_ts16_needs: assert property (@(posedge mclk) disable iff (!resetn)
        $rose(ts16Detect) |-> $past(raw.sigMfLost)) else $error("ts16 while aligned"); // RQ18
    c_irq_raise: cover property (@(posedge mclk) disable iff (!resetn) $rose(irq));
    c_read_clear: cover property (@(posedge mclk) disable iff (!resetn) rdFrameInd ##1 $fell(irq));
    c_reframe: cover property (@(posedge mclk) disable iff (!resetn) forceReframe);

endmodule : efa_alarm_irq
`default_nettype wire

//--- verilog/efa_defines.svh
// register offsets, field positions, reset values and timing counts
`ifndef EFA_DEFINES_SVH
`define EFA_DEFINES_SVH

`define EFA_ADDR_ALARM_EN     8'h23
`define EFA_ADDR_FRAME_IND    8'h24
`define EFA_ADDR_ALARM_IND    8'h25
`define EFA_ADDR_FRAME_STAT   8'h26
`define EFA_ADDR_ALARM_STAT   8'h27
`define EFA_ADDR_FRAME_EN     8'h22
`define EFA_ADDR_DEBOUNCE     8'h21

// alarm bit positions (enable, indication and status share them)
`define EFA_BIT_RRA           7
`define EFA_BIT_REMOTE_MF_ALARM          6
`define EFA_BIT_ALL_ONES_DETECT          5
`define EFA_BIT_TS16_ALL_ONES_DETECT       4
`define EFA_BIT_RED           3
`define EFA_BIT_AIS           2
`define EFA_BIT_FEBE          1
`define EFA_BIT_CRCE          0
// framing, framing control and debounce select bit positions
`define EFA_BIT_OOF           6
`define EFA_BIT_LOSS_OF_SIG_MULTIFRAME         5
`define EFA_BIT_LOSS_OF_CRC_MULTIFRAME         4
`define EFA_BIT_COFA          3
`define EFA_BIT_FER           2
`define EFA_BIT_SMFER         1
`define EFA_BIT_CMFER         0
`define EFA_BIT_TIMER_OFF     1
`define EFA_BIT_MFAS_OFF      0
`define EFA_BIT_REMOTE_ALARM_DEBOUNCE_SEL         3
`define EFA_BIT_REMOTE_MF_DEBOUNCE_SEL        2

`define EFA_RESET_BYTE        8'h00

// persistence timing at 125 MHz
`define EFA_CLK_PERIOD_NS     8
`define EFA_PERSIST_MS        100
`define EFA_PERSIST_CYCLES    ((`EFA_PERSIST_MS * 1000000) / `EFA_CLK_PERIOD_NS)
`define EFA_SEARCH_MS         8
`define EFA_SEARCH_CYCLES     ((`EFA_SEARCH_MS * 1000000) / `EFA_CLK_PERIOD_NS + 1)
`define EFA_MFAS_ERR_LIMIT    3'h4
`define EFA_CRC_ERR_LIMIT     10'h393

`endif

//--- verilog/efa_persist.sv
// persistence filter: output follows input only after it held steady
`timescale 1ns/1ps
`default_nettype none
module efa_persist
    import efa_pkg::*;
#(
    parameter int unsigned HOLD = 32'd12500000
)
(
    // clock and reset
    input  wire logic mclk,
    input  wire logic resetn,
    // condition and filtered state
    input  wire logic condition,
    output var  logic state
);
    import efa_pkg::*;

    logic [23:0]  count;
    efa_persist_t mode;
    wire          differs = (condition != state);
    wire          expired = (count >= HOLD[23:0] - 24'h000001);

    // any bounce restarts the count, so the hold must be continuous
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            count <= 24'h000000;
            state <= 1'b0;
            mode  <= EFA_IDLE;
        end
        else
        begin
            case (mode)
                EFA_IDLE:
                begin
                    count <= 24'h000000;
                    if (differs)
                        mode <= EFA_ACTIVE;
                end
                EFA_ACTIVE:
                begin
                    if (!differs)
                        mode <= EFA_IDLE;
                    else if (expired)
                        mode <= EFA_CLEAR;
                    else
                        count <= count + 24'h000001;
                end
                EFA_CLEAR:
                begin
                    state <= ~state;
                    count <= 24'h000000;
                    mode  <= EFA_IDLE;
                end
                default: mode <= EFA_IDLE;
            endcase
        end
    end

endmodule : efa_persist
`default_nettype wire

//--- verilog/efa_pkg.sv
// types shared by the alarm status and interrupt block
package efa_pkg;

    typedef struct packed {
        logic rxFrameErr;
        logic rxSigMfErr;
        logic rxCrcMfErr;
        logic rxAlignChange;
        logic rxCrcErr;
        logic rxFebeZero;
        logic secondTick;
    } efa_events_t;

    typedef struct packed {
        logic frameLost;
        logic sigMfLost;
        logic crcMfLost;
        logic crcMfSearch;
        logic nfasStrobe;
        logic remoteAlarmBit;
        logic mfStrobe;
        logic remoteMfBit;
        logic aisWindowStrobe;
        logic aisWindowOnes;
        logic ts16Strobe;
        logic ts16AllOnes;
    } efa_status_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } efa_bus_t;

    typedef enum logic [1:0] {
        EFA_IDLE   = 2'b00,
        EFA_ACTIVE = 2'b01,
        EFA_CLEAR  = 2'b10
    } efa_persist_t;

endpackage : efa_pkg
